// file: rtl/ecfr_top.sv
/*
  ECC fault and reset routing: takes non-correctable ECC events,
  escalates them to reset, fault unit and core, and keeps the
  capture registers over a functional reset; AXI4-Lite registers.
  Assumes event and capture inputs synchronous to mclk, one-cycle
  event pulses, and a toggle from the fault unit's own domain.
*/
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
// Summary of operation
// - an enabled multibit error also raises both critical fault outputs.
// - an enabled non-correctable event sets the memory ECC event flag.
// - fixed variant: disable and short bits read-only, reset at phase 1.
// - fixed variant: an enabled multibit error always resets.
// - capture registers keep their content through functional reset.
// - the report configuration is cleared during functional reset.
// - only the faulting memory's capture registers are updated.
// - configurable variant: the reset disable bit is writable.
// - disable set: safe mode request and machine check, no reset.
// - machine check comes twice with disable set (bus error, then fault unit NMI), otherwise once (NMI).
`timescale 1ns/1ps
`default_nettype none
`include "ecfr_consts.svh"

module ecfr_top
  import ecfr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        fixedVariant,
  input  wire logic        funcRstActive,
  input  wire logic        eccNcEvent,
  input  wire logic        eccIsFlash,
  input  wire ecfr_capt_s  eccCapt,
  input  wire logic        faultNmiToggle,
  output var  ecfr_esc_s   escOut,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `ECFR_OFF_ECR) || (a == `ECFR_OFF_ESR) ||
      (a == `ECFR_OFF_FES) || (a == `ECFR_OFF_FERD) ||
      (a == `ECFR_OFF_FESS) || (a == `ECFR_OFF_STAT) ||
      (a >= `ECFR_OFF_FL_ADDR && a <= `ECFR_OFF_FL_DLO &&
       a[1:0] == 2'h0) ||
      (a >= `ECFR_OFF_RM_ADDR && a <= `ECFR_OFF_RM_DLO &&
       a[1:0] == 2'h0);
  endfunction : isMapped

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]  ecr_r, ecr_nxt, esr_r, esr_nxt;
  logic        fes_r, fes_nxt, ferd_r, ferd_nxt, fess_r, fess_nxt;
  logic        fixed_r, fixed_nxt, strapTaken_r;
  logic [1:0]  pend_r, pend_nxt;
  ecfr_capt_s  flCap_r, flCap_nxt, rmCap_r, rmCap_nxt;
  ecfr_esc_s   esc_r, esc_nxt;
  logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [7:0]  wAddr_r, wAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic        wLane_r, wLane_nxt;
  logic        bvalid_r, bvalid_nxt, awready_r, awready_nxt;
  logic        wready_r, wready_nxt, arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        nmiPulse, report, wrFire, disEff, mcBus;
  logic [1:0]  pendSum;

  // ----------------------------------------------------------------
  // fault unit NMI crossing
  // ----------------------------------------------------------------
  ecfr_evt_sync u_nmi_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .evtToggle (faultNmiToggle),
    .evtPulse  (nmiPulse)
  );

  // event qualification by report enable and variant
  always_comb begin
    report = eccNcEvent && (eccIsFlash ? ecr_r[`ECFR_BIT_FLASH]
                                       : ecr_r[`ECFR_BIT_RAM]);
    disEff = !fixed_r && ferd_r;
    mcBus  = report && disEff;
    wrFire = awHeld_r && wHeld_r && !bvalid_r;
    pendSum = pend_r + {1'h0, nmiPulse} + {1'h0, mcBus};
  end

  // ----------------------------------------------------------------
  // control registers and escalation
  // ----------------------------------------------------------------
  always_comb begin
    ecr_nxt   = ecr_r;
    esr_nxt   = esr_r;
    fes_nxt   = fes_r;
    ferd_nxt  = ferd_r;
    fess_nxt  = fess_r;
    flCap_nxt = flCap_r;
    rmCap_nxt = rmCap_r;
    fixed_nxt = strapTaken_r ? fixed_r : fixedVariant;
    esc_nxt   = '0;
    // software writes, low byte lane
    if (wrFire && wLane_r) begin
      if (wAddr_r == `ECFR_OFF_ECR) begin
        ecr_nxt = wData_r[1:0];
      end else if (wAddr_r == `ECFR_OFF_ESR) begin
        esr_nxt = esr_r & ~wData_r[1:0];
      end else if (wAddr_r == `ECFR_OFF_FES) begin
        fes_nxt = fes_r & ~wData_r[`ECFR_BIT_EVT];
      end else if (wAddr_r == `ECFR_OFF_FERD) begin
        if (!fixed_r) begin
          ferd_nxt = wData_r[0];
        end
      end else if (wAddr_r == `ECFR_OFF_FESS) begin
        if (!fixed_r) begin
          fess_nxt = wData_r[0];
        end
      end
    end
    // hardware events win over clears
    if (report) begin
      esc_nxt.critFaultA = 1'h1;
      esc_nxt.critFaultB = 1'h1;
      fes_nxt = 1'h1;
      if (eccIsFlash) begin
        esr_nxt[`ECFR_BIT_FLASH] = 1'h1;
        flCap_nxt = eccCapt;
      end else begin
        esr_nxt[`ECFR_BIT_RAM] = 1'h1;
        rmCap_nxt = eccCapt;
      end
      if (!disEff) begin
        esc_nxt.resetReq      = 1'h1;
        esc_nxt.resetShortSeq = !fixed_r && fess_r;
      end else begin
        esc_nxt.safeModeReq = 1'h1;
      end
    end
    // one machine check per source, queued on collision
    esc_nxt.machineCheck = (pendSum != 2'h0);
    pend_nxt = (pendSum != 2'h0) ? pendSum - 2'h1 : 2'h0;
    // functional reset clears report configuration, keeps captures
    if (funcRstActive) begin
      ecr_nxt = `ECFR_RST_2B;
    end
  end

  // register the control state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ecr_r        <= `ECFR_RST_2B;
      esr_r        <= `ECFR_RST_2B;
      fes_r        <= 1'h0;
      ferd_r       <= 1'h0;
      fess_r       <= 1'h0;
      fixed_r      <= 1'h1;
      strapTaken_r <= 1'h0;
      pend_r       <= 2'h0;
      flCap_r      <= `ECFR_RST_CAPT;
      rmCap_r      <= `ECFR_RST_CAPT;
      esc_r        <= '0;
    end else begin
      ecr_r        <= ecr_nxt;
      esr_r        <= esr_nxt;
      fes_r        <= fes_nxt;
      ferd_r       <= ferd_nxt;
      fess_r       <= fess_nxt;
      fixed_r      <= fixed_nxt;
      strapTaken_r <= 1'h1;
      pend_r       <= pend_nxt;
      flCap_r      <= flCap_nxt;
      rmCap_r      <= rmCap_nxt;
      esc_r        <= esc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    wAddr_nxt  = wAddr_r;
    wData_nxt  = wData_r;
    wLane_nxt  = wLane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    // address and data taken in either order
    if (s_axi_awvalid && awready_r) begin
      awHeld_nxt = 1'h1;
      wAddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      wHeld_nxt = 1'h1;
      wData_nxt = s_axi_wdata;
      wLane_nxt = s_axi_wstrb[0];
    end
    if (wrFire) begin
      awHeld_nxt = 1'h0;
      wHeld_nxt  = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt  = isMapped(wAddr_r) ? `ECFR_RESP_OKAY
                                     : `ECFR_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'h0;
    end
    awready_nxt = !awHeld_nxt;
    wready_nxt  = !wHeld_nxt;
    // read mux
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'h1;
      rresp_nxt  = isMapped(s_axi_araddr) ? `ECFR_RESP_OKAY
                                          : `ECFR_RESP_SLVERR;
      rdata_nxt  = 32'h0;
      if (s_axi_araddr == `ECFR_OFF_ECR) begin
        rdata_nxt[1:0] = ecr_r;
      end else if (s_axi_araddr == `ECFR_OFF_ESR) begin
        rdata_nxt[1:0] = esr_r;
      end else if (s_axi_araddr == `ECFR_OFF_FES) begin
        rdata_nxt[`ECFR_BIT_EVT] = fes_r;
      end else if (s_axi_araddr == `ECFR_OFF_FERD) begin
        rdata_nxt[0] = ferd_r;
      end else if (s_axi_araddr == `ECFR_OFF_FESS) begin
        rdata_nxt[0] = fess_r;
      end else if (s_axi_araddr == `ECFR_OFF_STAT) begin
        rdata_nxt[`ECFR_BIT_FIXED] = fixed_r;
        rdata_nxt[`ECFR_BIT_PEND]  = (pend_r != 2'h0);
      end else if (s_axi_araddr == `ECFR_OFF_FL_ADDR) begin
        rdata_nxt = flCap_r.addr;
      end else if (s_axi_araddr == `ECFR_OFF_FL_MAST) begin
        rdata_nxt[7:0] = flCap_r.master;
      end else if (s_axi_araddr == `ECFR_OFF_FL_ATTR) begin
        rdata_nxt[7:0] = flCap_r.attr;
      end else if (s_axi_araddr == `ECFR_OFF_FL_DHI) begin
        rdata_nxt = flCap_r.dataHi;
      end else if (s_axi_araddr == `ECFR_OFF_FL_DLO) begin
        rdata_nxt = flCap_r.dataLo;
      end else if (s_axi_araddr == `ECFR_OFF_RM_ADDR) begin
        rdata_nxt = rmCap_r.addr;
      end else if (s_axi_araddr == `ECFR_OFF_RM_SYND) begin
        rdata_nxt[7:0] = rmCap_r.syndrome;
      end else if (s_axi_araddr == `ECFR_OFF_RM_MAST) begin
        rdata_nxt[7:0] = rmCap_r.master;
      end else if (s_axi_araddr == `ECFR_OFF_RM_ATTR) begin
        rdata_nxt[7:0] = rmCap_r.attr;
      end else if (s_axi_araddr == `ECFR_OFF_RM_DHI) begin
        rdata_nxt = rmCap_r.dataHi;
      end else if (s_axi_araddr == `ECFR_OFF_RM_DLO) begin
        rdata_nxt = rmCap_r.dataLo;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'h0;
    end
    arready_nxt = !rvalid_nxt;
  end

  // register the bus state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r  <= 1'h0;
      wHeld_r   <= 1'h0;
      wAddr_r   <= 8'h0;
      wData_r   <= 32'h0;
      wLane_r   <= 1'h0;
      bvalid_r  <= 1'h0;
      bresp_r   <= `ECFR_RESP_OKAY;
      rvalid_r  <= 1'h0;
      rresp_r   <= `ECFR_RESP_OKAY;
      rdata_r   <= 32'h0;
      awready_r <= 1'h1;
      wready_r  <= 1'h1;
      arready_r <= 1'h1;
    end else begin
      awHeld_r  <= awHeld_nxt;
      wHeld_r   <= wHeld_nxt;
      wAddr_r   <= wAddr_nxt;
      wData_r   <= wData_nxt;
      wLane_r   <= wLane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // outputs straight from flops
  assign escOut        = esc_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_crit_faults: assert property (
    report |=> escOut.critFaultA && escOut.critFaultB)
    else $error("critical faults not raised");
  chk_event_flag: assert property (
    report |=> fes_r ##1 (fes_r || $past(wrFire)))
    else $error("event flag not set");
  chk_fixed_phase: assert property (
    report && fixed_r |=> escOut.resetReq && !escOut.resetShortSeq)
    else $error("fixed variant did not reset at first phase");
  chk_fixed_readonly: assert property (
    fixed_r && !ferd_r |=> !ferd_r && !escOut.safeModeReq)
    else $error("fixed variant disable bit changed");
  chk_enabled_reset: assert property (
    eccNcEvent && !eccIsFlash && ecr_r[0] && !disEff
      |=> escOut.resetReq)
    else $error("enabled error did not reset");
  chk_capture_hold: assert property (
    funcRstActive && !report |=> $stable(flCap_r) && $stable(rmCap_r))
    else $error("capture changed in functional reset");
  chk_config_clear: assert property (
    funcRstActive |=> ecr_r == 2'h0)
    else $error("report config not cleared");
  chk_other_mem: assert property (
    report && eccIsFlash |=> $stable(rmCap_r) && flCap_r == $past(eccCapt))
    else $error("wrong memory captured");
  chk_disable_write: assert property (
    wrFire && wLane_r && wAddr_r == `ECFR_OFF_FERD && !fixed_r
      |=> ferd_r == $past(wData_r[0]))
    else $error("disable bit not written");
  chk_safe_mode: assert property (
    mcBus |=> escOut.safeModeReq && escOut.machineCheck &&
      !escOut.resetReq)
    else $error("disabled error did not go to safe mode");
  chk_nmi_once: assert property (
    nmiPulse && pend_r == 2'h0 && !mcBus
      |=> escOut.machineCheck ##1 !escOut.machineCheck || nmiPulse ||
        mcBus || $past(nmiPulse))
    else $error("fault unit NMI not delivered once");

endmodule : ecfr_top

`default_nettype wire

// file: rtl/ecfr_consts.svh
/*
  Constants of the ECC fault and reset routing block: register
  offsets, field positions, reset values and bus answer codes.
  Assumes inclusion by bare name from files of this block.
*/
`ifndef ECFR_CONSTS_SVH
`define ECFR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ECFR_OFF_ECR      8'h00
`define ECFR_OFF_ESR      8'h04
`define ECFR_OFF_FES      8'h08
`define ECFR_OFF_FERD     8'h0C
`define ECFR_OFF_FESS     8'h10
`define ECFR_OFF_STAT     8'h14
`define ECFR_OFF_FL_ADDR  8'h20
`define ECFR_OFF_FL_MAST  8'h24
`define ECFR_OFF_FL_ATTR  8'h28
`define ECFR_OFF_FL_DHI   8'h2C
`define ECFR_OFF_FL_DLO   8'h30
`define ECFR_OFF_RM_ADDR  8'h40
`define ECFR_OFF_RM_SYND  8'h44
`define ECFR_OFF_RM_MAST  8'h48
`define ECFR_OFF_RM_ATTR  8'h4C
`define ECFR_OFF_RM_DHI   8'h50
`define ECFR_OFF_RM_DLO   8'h54

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ECFR_BIT_RAM      0
`define ECFR_BIT_FLASH    1
`define ECFR_BIT_EVT      0
`define ECFR_BIT_FIXED    0
`define ECFR_BIT_PEND     1

// ----------------------------------------------------------------
// reset values and answer codes
// ----------------------------------------------------------------
`define ECFR_RST_2B       2'h0
`define ECFR_RST_CAPT     120'h0
`define ECFR_RESP_OKAY    2'h0
`define ECFR_RESP_SLVERR  2'h2

`endif

// file: rtl/ecfr_pkg.sv
/*
  Types of the ECC fault and reset routing block.
  Assumes nothing of its surroundings.
*/
package ecfr_pkg;

  // ----------------------------------------------------------------
  // captured error information of one memory
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] dataHi;
    logic [31:0] dataLo;
    logic [7:0]  master;
    logic [7:0]  attr;
    logic [7:0]  syndrome;
  } ecfr_capt_s;

  // ----------------------------------------------------------------
  // escalation outputs toward reset, fault unit and core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic critFaultA;
    logic critFaultB;
    logic resetReq;
    logic resetShortSeq;
    logic safeModeReq;
    logic machineCheck;
  } ecfr_esc_s;

endpackage : ecfr_pkg

// file: rtl/ecfr_evt_sync.sv
/*
  Toggle event synchroniser: turns each toggle of a signal from
  the fault collection clock domain into one pulse on mclk.
  Assumes the toggle holds for at least two mclk periods.
*/
`timescale 1ns/1ps
`default_nettype none

module ecfr_evt_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic evtToggle,
  output var  logic evtPulse
);

  logic       meta_r, sync_r, last_r, pulse_r;
  logic       pulse_nxt;
  logic [1:0] warm_r, warm_nxt;

  // edge of the settled toggle only; the far domain keeps its toggle
  // level over our reset, so no edge until the chain has refilled
  always_comb begin
    warm_nxt  = (warm_r == 2'h3) ? warm_r : warm_r + 2'h1;
    pulse_nxt = (warm_r == 2'h3) && (sync_r ^ last_r);
  end

  // two stages, then edge memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r  <= 1'h0;
      sync_r  <= 1'h0;
      last_r  <= 1'h0;
      pulse_r <= 1'h0;
      warm_r  <= 2'h0;
    end else begin
      meta_r  <= evtToggle;
      sync_r  <= meta_r;
      last_r  <= sync_r;
      pulse_r <= pulse_nxt;
      warm_r  <= warm_nxt;
    end
  end

  assign evtPulse = pulse_r;

endmodule : ecfr_evt_sync

`default_nettype wire

// file: sim/ecfr_fault_model.sv
/*
  Behavioural fault collection unit: raises its non-maskable
  interrupt toggle some time after each critical fault pulse.
  Assumes escalation pulses on mclk; runs on its own clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ecfr_fault_model
  import ecfr_pkg::*;
(
  input  wire logic      mclk,
  input  wire ecfr_esc_s escIn,
  input  wire logic      slowMode,
  output var  logic      nmiToggle
);
  logic fClk = 1'b0;
  int   reqCnt = 0;
  int   ackCnt = 0;

  // own clock, unrelated in phase and rate to mclk
  initial begin
    forever #17 fClk = ~fClk;
  end

  // count critical faults, sampled mid-cycle where they are settled
  always @(negedge mclk) begin
    if (escIn.critFaultA === 1'b1) reqCnt <= reqCnt + 1;
  end

  // answer each fault with one nmi toggle, promptly or slowly
  initial nmiToggle = 1'b0;
  always @(posedge fClk) begin
    if (reqCnt != ackCnt) begin
      repeat (slowMode ? 20 : 2) @(posedge fClk);
      nmiToggle <= ~nmiToggle;
      ackCnt    <= ackCnt + 1;
    end
  end
endmodule : ecfr_fault_model

`default_nettype wire

// file: sim/testbench.sv
/*
  Testbench of the ECC fault and reset routing block: register
  tasks over AXI4-Lite, event pulses and escalation checks.
  Assumes the fault model on the nmi toggle input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ecfr_consts.svh"

module testbench
  import ecfr_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fixedVariant = 1'b0;
  logic        funcRstActive = 1'b0;
  logic        eccNcEvent = 1'b0;
  logic        eccIsFlash = 1'b0;
  ecfr_capt_s  eccCapt = '0;
  logic        faultNmiToggle;
  logic        slowMode = 1'b0;
  ecfr_esc_s   escOut;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          mcCnt = 0;
  int          mcBase;
  logic [1:0]  resp;
  ecfr_capt_s  cA;
  ecfr_capt_s  cB;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  ecfr_top u_ecfr_top (
    .mclk(mclk), .rst_n(rst_n), .fixedVariant(fixedVariant),
    .funcRstActive(funcRstActive), .eccNcEvent(eccNcEvent),
    .eccIsFlash(eccIsFlash), .eccCapt(eccCapt),
    .faultNmiToggle(faultNmiToggle), .escOut(escOut),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  ecfr_fault_model u_ecfr_fault_model (
    .mclk(mclk), .escIn(escOut), .slowMode(slowMode),
    .nmiToggle(faultNmiToggle)
  );

  // clock and machine check pulse counter
  initial begin
    forever #25 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (escOut.machineCheck === 1'b1) mcCnt <= mcCnt + 1;
  end

  // ----------------------------------------------------------------
  // compare, bus and event tasks
  // ----------------------------------------------------------------
  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : checkVal

  task automatic checkEsc(input ecfr_esc_s got, input ecfr_esc_s exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected escalation at %0t: got %b want %b", $time, got,
               exp);
    end
  endtask : checkEsc

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
    logic awDone;
    logic wDone;
    logic awHit;
    logic wHit;
    logic bHit;
    awDone = 1'b0;
    wDone = 1'b0;
    bHit = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // ready read mid-cycle, the item moves at the next rising edge
    while (!(awDone && wDone)) begin
      @(negedge mclk);
      awHit = !awDone && awready === 1'b1;
      wHit = !wDone && wready === 1'b1;
      @(posedge mclk);
      if (awHit) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wHit) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bHit) begin
      @(negedge mclk);
      bHit = bvalid === 1'b1;
      r = bresp;
      @(posedge mclk);
    end
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    logic arHit;
    logic rHit;
    arHit = 1'b0;
    rHit = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // handshakes judged mid-cycle, completed at the next rising edge
    while (!arHit) begin
      @(negedge mclk);
      arHit = arready === 1'b1;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    while (!rHit) begin
      @(negedge mclk);
      rHit = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge mclk);
    end
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axiRead

  // write a register and expect an okay answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axiWrite(a, d, resp);
    checkVal({30'h0, resp}, {30'h0, `ECFR_RESP_OKAY});
  endtask : wr

  // read a register and compare data and answer
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] expResp);
    logic [31:0] d;
    axiRead(a, d, resp);
    checkVal(d, exp);
    checkVal({30'h0, resp}, {30'h0, expResp});
  endtask : rdChk

  // one event pulse, escalation checked in the following cycle
  task automatic fire(input logic fl, input ecfr_capt_s c,
                      input ecfr_esc_s exp);
    eccIsFlash <= fl;
    eccCapt <= c;
    eccNcEvent <= 1'b1;
    @(posedge mclk);
    eccNcEvent <= 1'b0;
    @(negedge mclk);
    checkEsc(escOut, exp);
    repeat (60) @(posedge mclk);
  endtask : fire

  function automatic ecfr_esc_s esc(input logic rs, input logic sh,
                                    input logic sm);
    return '{critFaultA: 1'b1, critFaultB: 1'b1, resetReq: rs,
             resetShortSeq: sh, safeModeReq: sm, machineCheck: sm};
  endfunction : esc

  task automatic doReset(input logic fv);
    rst_n <= 1'b0;
    fixedVariant <= fv;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask : doReset

  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cA = '{32'h0000_1F08, 32'hCAFE_BEEF, 32'h1234_5678, 8'h03, 8'h21, 8'h5A};
    cB = '{32'h00F0_0010, 32'h0BAD_F00D, 32'h8765_4321, 8'h01, 8'h42, 8'h00};
    doReset(1'b0);
    rdChk(`ECFR_OFF_STAT, 32'h0, `ECFR_RESP_OKAY);
    rdChk(8'h18, 32'h0, `ECFR_RESP_SLVERR);
    fire(1'b0, cA, '0);
    rdChk(`ECFR_OFF_FES, 32'h0, `ECFR_RESP_OKAY);
    wr(`ECFR_OFF_ECR, 32'h1);
    fire(1'b0, cA, esc(1'b1, 1'b0, 1'b0));
    rdChk(`ECFR_OFF_FES, 32'h1, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_ESR, 32'h1, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_RM_ADDR, cA.addr, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_FL_ADDR, 32'h0, `ECFR_RESP_OKAY);
    wr(`ECFR_OFF_ESR, 32'h33);
    wr(`ECFR_OFF_FES, 32'h1);
    rdChk(`ECFR_OFF_ESR, 32'h0, `ECFR_RESP_OKAY);
    funcRstActive <= 1'b1;
    repeat (3) @(posedge mclk);
    funcRstActive <= 1'b0;
    @(posedge mclk);
    rdChk(`ECFR_OFF_ECR, 32'h0, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_RM_DLO, cA.dataLo, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_RM_SYND, 32'h5A, `ECFR_RESP_OKAY);
    fire(1'b0, cB, '0);
    wr(`ECFR_OFF_ECR, 32'h3);
    wr(`ECFR_OFF_FESS, 32'h1);
    slowMode <= 1'b1;
    fire(1'b1, cB, esc(1'b1, 1'b1, 1'b0));
    rdChk(`ECFR_OFF_FL_MAST, 32'h1, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_RM_ADDR, cA.addr, `ECFR_RESP_OKAY);
    wr(`ECFR_OFF_FERD, 32'h1);
    rdChk(`ECFR_OFF_FERD, 32'h1, `ECFR_RESP_OKAY);
    mcBase = mcCnt;
    fire(1'b1, cA, esc(1'b0, 1'b0, 1'b1));
    checkVal(mcCnt - mcBase, 32'h2);
    slowMode <= 1'b0;
    mcBase = mcCnt;
    fire(1'b0, cB, esc(1'b0, 1'b0, 1'b1));
    checkVal(mcCnt - mcBase, 32'h2);
    doReset(1'b1);
    rdChk(`ECFR_OFF_STAT, 32'h1, `ECFR_RESP_OKAY);
    wr(`ECFR_OFF_FERD, 32'h1);
    wr(`ECFR_OFF_FESS, 32'h1);
    rdChk(`ECFR_OFF_FERD, 32'h0, `ECFR_RESP_OKAY);
    rdChk(`ECFR_OFF_FESS, 32'h0, `ECFR_RESP_OKAY);
    wr(`ECFR_OFF_ECR, 32'h1);
    fire(1'b0, cA, esc(1'b1, 1'b0, 1'b0));
    final_report();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
